// [rtl/exu_pkg.sv]
// Purpose: Shared types and constants of the execute datapath.
// Assumes: One core clock; operands arrive already read from the register file.
// Notes: Flag bit positions follow the status byte layout used by the core.
package exu_pkg;
  // ----------------------------------------------------------------------
  // Status flag positions and reset values
  // ----------------------------------------------------------------------
  localparam int FLG_C = 0; // Carry
  localparam int FLG_Z = 1; // Zero
  localparam int FLG_N = 2; // Negative
  localparam int FLG_V = 3; // Overflow
  localparam int FLG_S = 4; // Sign
  localparam int FLG_H = 5; // Half carry
  localparam int FLG_T = 6; // Transfer bit
  localparam logic [7:0] FLAGS_RST = 8'h00; // Flags after reset
  localparam logic [15:0] WORD_RST = 16'h0000; // Result words after reset
  localparam logic [7:0] BYTE_ALL = 8'hFF; // All-ones byte for bit clear

  // ----------------------------------------------------------------------
  // Cycle counts and program counter steps
  // ----------------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [15:0] PC_STEP = 16'h0001; // Next sequential word
  localparam logic [15:0] PC_SKIP1 = 16'h0002; // Skip a one-word instruction
  localparam logic [15:0] PC_SKIP2 = 16'h0003; // Skip a two-word instruction

  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, word_add_immediate, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY,
    sub_carry_immediate, word_sub_immediate, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
    OP_XOR, bit_clear_op, bit_set_op, zero_minus_test, OP_MUL, OP_MUL_SIGNED,
    mult_signed_unsigned, OP_FMUL, OP_FMUL_SIGNED, frac_mult_signed_unsigned,
    relative_call, compare_skip_equal, compare_immediate, skip_reg_bit_clear,
    skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set, branch_status_set,
    branch_status_clear, branch_signed_ge, branch_signed_lt, branch_unsigned_ge,
    branch_unsigned_lt, branch_half_carry_set, branch_half_carry_clear,
    branch_overflow_set, branch_overflow_clear, branch_transfer_bit_set,
    branch_transfer_bit_clear
  } exu_op_t;

  // Controller states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } exu_st_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    exu_op_t op; // Operation
    logic [7:0] opa; // Rd value
    logic [7:0] opb; // Rr value or constant K
    logic [15:0] pair; // Register pair value for word ops
    logic [2:0] bsel; // Bit index b or status bit s
    logic [7:0] io; // I/O register value for I/O skips
    logic [15:0] pc; // Address of this instruction
    logic [11:0] offset; // Signed relative offset k
    logic two_word; // Following instruction is two words long
  } exu_req_t;

  typedef struct packed {
    logic wr_rd; // Write data[7:0] to Rd
    logic wr_pair; // Write data to the register pair
    logic wr_prod; // Write data to registers one and zero
    logic push_ret; // Save ret_addr as return address
    logic [15:0] data; // Result value
    logic [15:0] pc_next; // New program counter
    logic [15:0] ret_addr; // Return address of a call
  } exu_res_t;

  typedef struct packed {
    exu_st_t st; // Controller state
    logic [1:0] cnt; // Remaining cycles
    logic done; // Completion pulse
    logic busy; // Operation in progress
    logic [7:0] flags; // Status flags
    exu_res_t res; // Registered result
  } exu_state_t;
endpackage

// [rtl/exu_execute.sv]
// Purpose: Execute datapath: ALU, word ops, multiplies, skips and branches.
// Assumes: Requests come from same-clock decode logic; one request at a time.
// Notes: Result, flags and next PC are valid from the done pulse onward.

// Notes on behaviour
// - add forms write sum, five flags, one cycle
// - word add immediate on pair, two cycles
// - subtract forms write difference, one cycle
// - word subtract immediate on pair, two cycles
// - logic ops touch only Z, N, V
// - bit clear ANDs with all-ones minus K
// - bit set ORs constant in, one cycle
// - zero-minus test sets flags, keeps Rd
// - multiplies write product to R1:R0, two cycles
// - fractional multiplies shift product left once
// - relative call jumps k+1, saves return, three cycles
// - compare-skip-equal skips when operands match
// - I/O bit skips test bit b
// - status branches use bit s, 1/2 cycles
// - signed branches use N xor V
// - unsigned branches use carry
// - half-carry branches use H
// - overflow branches use V
// - transfer-bit branches use T
module exu_execute
  import exu_pkg::*;
(
  input wire logic mclk_in, // Core clock
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic ce_in, // Clock enable, freezes all state when low
  input wire logic start_in, // Request strobe
  input wire exu_req_t req_in, // Request fields
  input wire logic flag_load_in, // Load flags from flag_value_in while idle and no request is accepted
  input wire logic [7:0] flag_value_in, // Flag value to load
  output logic done_out, // Completion pulse
  output logic busy_out, // Operation in progress
  output logic [7:0] flags_out, // Status flags
  output exu_res_t res_out // Result of last operation
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  exu_state_t q; // Registered state
  exu_state_t next_q; // Next state
  logic acc; // Request accepted this cycle

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------
  logic [7:0] a, b, r8; // Operands and byte result
  logic cin; // Carry into add or subtract
  logic [15:0] k16, pw; // Sign-extended offset, word result
  logic signed [17:0] prod; // Full product
  logic skip, take; // Skip and branch decisions
  logic [1:0] cyc; // Cycle count of this request
  exu_res_t nr; // New result
  logic [7:0] nf; // New flags

  assign acc = ce_in & start_in & (q.st == ST_IDLE);
  assign a = req_in.opa;
  assign b = req_in.opb;
  assign k16 = {{4{req_in.offset[11]}}, req_in.offset};

  // Multiplier with per-operand sign extension
  always_comb begin
    logic sa, sb;
    sa = 1'b0;
    sb = 1'b0;
    unique case (req_in.op)
      OP_MUL_SIGNED, OP_FMUL_SIGNED: begin
        sa = a[7];
        sb = b[7];
      end
      mult_signed_unsigned, frac_mult_signed_unsigned: begin
        sa = a[7];
      end
      default: begin
      end
    endcase
    prod = $signed({sa, a}) * $signed({sb, b});
  end

  // Skip and branch condition evaluation
  always_comb begin
    skip = 1'b0;
    take = 1'b0;
    unique case (req_in.op)
      compare_skip_equal: skip = (a == b);
      skip_reg_bit_clear: skip = ~a[req_in.bsel];
      skip_reg_bit_set: skip = a[req_in.bsel];
      skip_io_bit_clear: skip = ~req_in.io[req_in.bsel];
      skip_io_bit_set: skip = req_in.io[req_in.bsel];
      branch_status_set: take = q.flags[req_in.bsel];
      branch_status_clear: take = ~q.flags[req_in.bsel];
      branch_signed_ge: take = ~(q.flags[FLG_N] ^ q.flags[FLG_V]);
      branch_signed_lt: take = q.flags[FLG_N] ^ q.flags[FLG_V];
      branch_unsigned_ge: take = ~q.flags[FLG_C];
      branch_unsigned_lt: take = q.flags[FLG_C];
      branch_half_carry_set: take = q.flags[FLG_H];
      branch_half_carry_clear: take = ~q.flags[FLG_H];
      branch_overflow_set: take = q.flags[FLG_V];
      branch_overflow_clear: take = ~q.flags[FLG_V];
      branch_transfer_bit_set: take = q.flags[FLG_T];
      branch_transfer_bit_clear: take = ~q.flags[FLG_T];
      default: begin
      end
    endcase
  end

  // Operation result, flags, next PC and cycle count
  always_comb begin
    nf = q.flags; // Unnamed flags hold
    nr = '0;
    nr.pc_next = req_in.pc + PC_STEP;
    cin = 1'b0;
    r8 = 8'h00;
    pw = 16'h0000;
    cyc = CYC_ONE;
    unique case (req_in.op)
      // Add forms
      OP_ADD, OP_ADD_CARRY: begin
        cin = (req_in.op == OP_ADD_CARRY) & q.flags[FLG_C];
        r8 = 8'(a + b + {7'h00, cin});
        nr.wr_rd = 1'b1;
        nf[FLG_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
        nf[FLG_C] = (a[7] & b[7]) | (b[7] & ~r8[7]) | (~r8[7] & a[7]);
        nf[FLG_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
        nf[FLG_N] = r8[7];
        nf[FLG_Z] = (r8 == 8'h00);
      end
      // Subtract and compare forms
      OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, sub_carry_immediate, compare_immediate: begin
        cin = (req_in.op == OP_SUB_CARRY || req_in.op == sub_carry_immediate) &
              q.flags[FLG_C];
        r8 = 8'(a - b - {7'h00, cin});
        nr.wr_rd = (req_in.op != compare_immediate);
        nf[FLG_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
        nf[FLG_C] = (~a[7] & b[7]) | (b[7] & r8[7]) | (r8[7] & ~a[7]);
        nf[FLG_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
        nf[FLG_N] = r8[7];
        // Carry forms keep zero only while the whole chain is zero
        nf[FLG_Z] = (r8 == 8'h00) & (~(req_in.op == OP_SUB_CARRY ||
                    req_in.op == sub_carry_immediate) | q.flags[FLG_Z]);
      end
      // Word add and subtract on a pair
      word_add_immediate, word_sub_immediate: begin
        if (req_in.op == word_add_immediate) begin
          pw = req_in.pair + {10'h000, b[5:0]};
          nf[FLG_V] = ~req_in.pair[15] & pw[15];
          nf[FLG_C] = ~pw[15] & req_in.pair[15];
        end else begin
          pw = req_in.pair - {10'h000, b[5:0]};
          nf[FLG_V] = req_in.pair[15] & ~pw[15];
          nf[FLG_C] = pw[15] & ~req_in.pair[15];
        end
        nr.wr_pair = 1'b1;
        nr.data = pw;
        nf[FLG_N] = pw[15];
        nf[FLG_Z] = (pw == 16'h0000);
        nf[FLG_S] = pw[15] ^ nf[FLG_V];
        cyc = CYC_TWO;
      end
      // Bitwise forms
      OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, bit_clear_op, bit_set_op,
      zero_minus_test: begin
        unique case (req_in.op)
          OP_AND, OP_AND_IMM: r8 = a & b;
          OP_OR, OP_OR_IMM, bit_set_op: r8 = a | b;
          OP_XOR: r8 = a ^ b;
          bit_clear_op: r8 = a & (BYTE_ALL - b);
          default: r8 = a & a;
        endcase
        nr.wr_rd = (req_in.op != zero_minus_test);
        nf[FLG_V] = 1'b0;
        nf[FLG_N] = r8[7];
        nf[FLG_Z] = (r8 == 8'h00);
      end
      // Multiplies
      OP_MUL, OP_MUL_SIGNED, mult_signed_unsigned, OP_FMUL, OP_FMUL_SIGNED,
      frac_mult_signed_unsigned: begin
        if (req_in.op == OP_FMUL || req_in.op == OP_FMUL_SIGNED ||
            req_in.op == frac_mult_signed_unsigned) begin
          pw = {prod[14:0], 1'b0};
        end else begin
          pw = prod[15:0];
        end
        nr.wr_prod = 1'b1;
        nr.data = pw;
        nf[FLG_C] = prod[15];
        nf[FLG_Z] = (pw == 16'h0000);
        cyc = CYC_TWO;
      end
      // Relative call
      relative_call: begin
        nr.pc_next = req_in.pc + k16 + PC_STEP;
        nr.ret_addr = req_in.pc + PC_STEP;
        nr.push_ret = 1'b1;
        cyc = CYC_THREE;
      end
      // Skips past the whole next instruction
      compare_skip_equal, skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear,
      skip_io_bit_set: begin
        if (skip) begin
          nr.pc_next = req_in.pc + (req_in.two_word ? PC_SKIP2 : PC_SKIP1);
          cyc = req_in.two_word ? CYC_THREE : CYC_TWO;
        end
      end
      // Conditional branches
      default: begin
        if (take) begin
          nr.pc_next = req_in.pc + k16 + PC_STEP;
          cyc = CYC_TWO;
        end
      end
    endcase
    if (nr.wr_rd) begin
      nr.data = {8'h00, r8};
    end
  end

  // ----------------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------------
  // Next-state logic: count the cycles of the accepted operation
  always_comb begin
    next_q = q;
    if (ce_in) begin
      next_q.done = 1'b0;
      unique case (q.st)
        ST_IDLE: begin
          if (acc) begin
            next_q.res = nr;
            next_q.flags = nf;
            next_q.cnt = cyc - CYC_ONE;
            if (cyc == CYC_ONE) begin
              next_q.done = 1'b1; // Single-cycle operation
            end else begin
              next_q.st = ST_BUSY;
              next_q.busy = 1'b1;
            end
          end else if (flag_load_in) begin
            next_q.flags = flag_value_in; // Software write of status flags
          end
        end
        ST_BUSY: begin
          next_q.cnt = q.cnt - CYC_ONE;
          if (q.cnt == CYC_ONE) begin
            next_q.done = 1'b1;
            next_q.busy = 1'b0;
            next_q.st = ST_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{st: ST_IDLE, cnt: 2'h0, done: 1'b0, busy: 1'b0, flags: FLAGS_RST,
             res: '{wr_rd: 1'b0, wr_pair: 1'b0, wr_prod: 1'b0, push_ret: 1'b0,
                    data: WORD_RST, pc_next: WORD_RST, ret_addr: WORD_RST}};
    end else begin
      q <= next_q;
    end
  end

  assign done_out = q.done;
  assign busy_out = q.busy;
  assign flags_out = q.flags;
  assign res_out = q.res;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_add_sum: assert property (acc && req_in.op == OP_ADD |=>
    q.done && q.res.data[7:0] == 8'($past(req_in.opa) + $past(req_in.opb)))
    else $error("add result or timing wrong");
  a_word_cycles: assert property (acc && req_in.op == word_add_immediate |=>
    (!q.done && q.busy && q.cnt == CYC_ONE) and
    (ce_in |=> q.done && q.res.wr_pair))
    else $error("word add not two cycles");
  a_sub_diff: assert property (acc && req_in.op == OP_SUB |=>
    q.res.data[7:0] == 8'($past(req_in.opa) - $past(req_in.opb)) && q.res.wr_rd)
    else $error("subtract result wrong");
  a_logic_keep: assert property (acc && req_in.op == OP_XOR |=>
    !q.flags[FLG_V] && $stable(q.flags[FLG_C]) && $stable(q.flags[FLG_H]))
    else $error("logic op touched wrong flags");
  a_bit_clear: assert property (acc && req_in.op == bit_clear_op |=>
    q.res.data[7:0] == ($past(req_in.opa) & ~$past(req_in.opb)))
    else $error("bit clear result wrong");
  a_test_hold: assert property (acc && req_in.op == zero_minus_test |=>
    !q.res.wr_rd && q.flags[FLG_Z] == ($past(req_in.opa) == 8'h00))
    else $error("test wrote register or bad zero");
  a_mul_prod: assert property (acc && req_in.op == OP_MUL |=>
    q.res.data == {8'h00, $past(req_in.opa)} * {8'h00, $past(req_in.opb)})
    else $error("unsigned product wrong");
  a_call_time: assert property (acc && req_in.op == relative_call ##1 ce_in ##1 ce_in
    |=> q.done && q.res.push_ret)
    else $error("call not three cycles");
  a_call_flags: assert property (acc && req_in.op == relative_call |=>
    $stable(q.flags) && q.res.ret_addr == $past(req_in.pc) + PC_STEP)
    else $error("call changed flags or bad return");
  a_skip_two: assert property (acc && skip && req_in.two_word |=>
    q.res.pc_next == $past(req_in.pc) + PC_SKIP2 && q.cnt == CYC_TWO)
    else $error("two-word skip wrong");
  a_branch_miss: assert property (acc && take == 1'b0 &&
    req_in.op == branch_unsigned_lt |=> q.done && q.res.pc_next == $past(req_in.pc) + PC_STEP)
    else $error("untaken branch wrong");
  // Controller timing and less common datapath forms
  a_busy_hold: assert property (q.st == ST_BUSY |=>
    $stable(q.flags) && $stable(q.res))
    else $error("busy cycle changed result or flags");
  a_done_once: assert property (q.done && ce_in && !acc |=>
    !q.done)
    else $error("done stood longer than one cycle");
  a_sbc_chain: assert property (acc && req_in.op == OP_SUB_CARRY &&
    !q.flags[FLG_Z] |=> !q.flags[FLG_Z])
    else $error("carry subtract set zero");
  a_fmul_shift: assert property (acc && req_in.op == OP_FMUL |=>
    q.res.data == 16'(({8'h00, $past(req_in.opa)} * {8'h00, $past(req_in.opb)}) << 1))
    else $error("fractional product not shifted");
  a_branch_take: assert property (acc && take |=>
    q.res.pc_next == 16'($past(req_in.pc) + $past(k16) + PC_STEP) && q.cnt == CYC_ONE)
    else $error("taken branch target or time wrong");
  a_io_skip: assert property (acc && req_in.op == skip_io_bit_set &&
    !req_in.io[req_in.bsel] |=> q.done && q.res.pc_next == $past(req_in.pc) + PC_STEP)
    else $error("unskipped I/O test wrong");

  c_branch_taken: cover property (acc && take);
  c_skip_taken: cover property (acc && skip);
  c_frac_mul: cover property (acc && req_in.op == frac_mult_signed_unsigned ##2 q.done);
  c_carry_chain: cover property (acc && req_in.op == OP_ADD_CARRY && q.flags[FLG_C]);
  c_flag_load: cover property (q.st == ST_IDLE && flag_load_in && ce_in && !acc);
endmodule

// [verification/cpu_alu_branch_execute_tb_top.sv]
// Purpose: Self-checking bench for the execute datapath.
// Assumes: Inputs change on the falling clock edge; results are read at done.
// Notes: Flags are preset through the flag load port before each case that follows reset.
module cpu_alu_branch_execute_tb_top
  import exu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic mclk_in = 1'b0; // Core clock
  logic rst_in = 1'b1; // Reset, held at start
  logic ce_in = 1'b1; // Clock enable
  logic start_in = 1'b0; // Request strobe
  logic flag_load_in = 1'b0; // Flag preset strobe
  logic [7:0] flag_value_in = 8'h00; // Flag preset value
  exu_req_t req_in = '0; // Request driven to the block
  exu_req_t rq = '0; // Request being prepared
  logic done_out;
  logic busy_out;
  logic [7:0] flags_out;
  exu_res_t res_out;
  int fails = 0; // Mismatch count
  int total_checks = 0; // Comparison count

  exu_execute uut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .start_in(start_in),
    .req_in(req_in), .flag_load_in(flag_load_in), .flag_value_in(flag_value_in),
    .done_out(done_out), .busy_out(busy_out), .flags_out(flags_out), .res_out(res_out));

  // Free-running 100 MHz clock
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // ----------------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t bit got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------
  // Preset the flags while idle
  task automatic preload(input logic [7:0] v);
    @(negedge mclk_in);
    flag_load_in = 1'b1;
    flag_value_in = v;
    @(negedge mclk_in);
    flag_load_in = 1'b0;
  endtask

  // Prepare a request with default side fields
  task automatic mk(input exu_op_t op, input logic [7:0] a, input logic [7:0] b);
    rq = '0;
    rq.op = op;
    rq.opa = a;
    rq.opb = b;
    rq.pc = 16'h0100;
  endtask

  // Issue rq, wait for done under a bound and check the cycle count
  task automatic go(input logic [1:0] cyc);
    int n;
    @(negedge mclk_in);
    start_in = 1'b1;
    req_in = rq;
    @(negedge mclk_in);
    start_in = 1'b0;
    n = 1;
    while (done_out !== 1'b1 && n < 8) begin
      @(negedge mclk_in);
      n++;
    end
    if (done_out !== 1'b1) begin
      fails++;
      end_of_test();
    end
    cmp_word(16'(n), {14'h0000, cyc});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values of flags, done, busy and result data
  task automatic t_reset();
    cmp_flags(flags_out, FLAGS_RST);
    cmp_bit(done_out, 1'b0);
    cmp_bit(busy_out, 1'b0);
    cmp_word(res_out.data, WORD_RST);
  endtask

  // Byte add, subtract and compare with flag corner cases
  task automatic t_arith();
    preload(8'hD1);
    mk(OP_ADD, 8'h7F, 8'h01);
    go(CYC_ONE);
    cmp_word(res_out.data, 16'h0080);
    cmp_flags(flags_out, 8'hFC);
    preload(8'h01);
    mk(OP_ADD_CARRY, 8'hFF, 8'h00);
    go(CYC_ONE);
    cmp_word(res_out.data, 16'h0000);
    cmp_flags(flags_out, 8'h23);
    preload(8'h40);
    mk(OP_SUB, 8'h10, 8'h01);
    go(CYC_ONE);
    cmp_word(res_out.data, 16'h000F);
    cmp_flags(flags_out, 8'h60);
    preload(8'h00);
    mk(sub_carry_immediate, 8'h05, 8'h05);
    go(CYC_ONE);
    cmp_flags(flags_out, 8'h00);
    preload(8'h02);
    go(CYC_ONE);
    cmp_flags(flags_out, 8'h02);
    preload(8'h01);
    mk(OP_SUB_CARRY, 8'h05, 8'h04);
    go(CYC_ONE);
    cmp_word(res_out.data, 16'h0000);
    cmp_flags(flags_out, 8'h00);
    preload(8'h03);
    go(CYC_ONE);
    cmp_flags(flags_out, 8'h02);
    preload(8'h00);
    mk(compare_immediate, 8'h20, 8'h30);
    go(CYC_ONE);
    cmp_bit(res_out.wr_rd, 1'b0);
    cmp_flags(flags_out, 8'h05);
  endtask

  // Word add and subtract on a register pair
  task automatic t_word();
    preload(8'h20);
    mk(word_add_immediate, 8'h00, 8'h01);
    rq.pair = 16'hFFFF;
    go(CYC_TWO);
    cmp_bit(res_out.wr_pair, 1'b1);
    cmp_word(res_out.data, 16'h0000);
    cmp_flags(flags_out, 8'h23);
    preload(8'h00);
    mk(word_sub_immediate, 8'h00, 8'hC1);
    rq.pair = 16'h8000;
    go(CYC_TWO);
    cmp_word(res_out.data, 16'h7FFF);
    cmp_flags(flags_out, 8'h18);
  endtask

  // Logic ops keep C, S, H, T and bit 7, clear V
  task automatic t_logic();
    exu_op_t ops[9] = '{OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, bit_clear_op,
      bit_set_op, zero_minus_test, bit_clear_op};
    logic [7:0] ex[9] = '{8'h80, 8'h80, 8'hFF, 8'hFF, 8'h7F, 8'h70, 8'hFF, 8'hF0, 8'h00};
    for (int i = 0; i < 9; i++) begin
      preload(8'hFF);
      mk(ops[i], 8'hF0, (i == 8) ? 8'hF0 : 8'h8F);
      go(CYC_ONE);
      cmp_bit(res_out.wr_rd, i != 7);
      cmp_word(res_out.data, (i == 7) ? 16'h0000 : {8'h00, ex[i]});
      cmp_flags(flags_out, {5'h1E, ex[i][7], ex[i] == 8'h00, 1'b1});
    end
  endtask

  // All multiplies on 0x80 by 0xFF
  task automatic t_mul();
    exu_op_t ops[6] = '{OP_MUL, OP_MUL_SIGNED, mult_signed_unsigned, OP_FMUL,
      OP_FMUL_SIGNED, frac_mult_signed_unsigned};
    logic [15:0] ex[6] = '{16'h7F80, 16'h0080, 16'h8080, 16'hFF00, 16'h0100, 16'h0100};
    logic cy[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++) begin
      preload(8'h7C);
      mk(ops[i], 8'h80, 8'hFF);
      go(CYC_TWO);
      cmp_bit(res_out.wr_prod, 1'b1);
      cmp_word(res_out.data, ex[i]);
      cmp_flags(flags_out, {7'h3E, cy[i]});
    end
  endtask

  // Relative call backwards, flags untouched
  task automatic t_call();
    preload(8'hA5);
    mk(relative_call, 8'h00, 8'h00);
    rq.offset = 12'hFFE;
    go(CYC_THREE);
    cmp_word(res_out.pc_next, 16'h00FF);
    cmp_word(res_out.ret_addr, 16'h0101);
    cmp_bit(res_out.push_ret, 1'b1);
    cmp_flags(flags_out, 8'hA5);
  endtask

  // Skips taken over one- and two-word followers, not taken over one-word followers
  task automatic t_skip();
    exu_op_t ops[7] = '{compare_skip_equal, compare_skip_equal, compare_skip_equal,
      skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set};
    logic [7:0] b[7] = '{8'h08, 8'h09, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08};
    logic tw[7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [15:0] st[7] = '{PC_SKIP1, PC_STEP, PC_SKIP2, PC_STEP, PC_SKIP2, PC_SKIP1, PC_STEP};
    logic [1:0] cy[7] = '{CYC_TWO, CYC_ONE, CYC_THREE, CYC_ONE, CYC_THREE, CYC_TWO, CYC_ONE};
    for (int i = 0; i < 7; i++) begin
      preload(8'h5A);
      mk(ops[i], 8'h08, b[i]);
      rq.bsel = 3'h3;
      rq.io = 8'hF7;
      rq.two_word = tw[i];
      go(cy[i]);
      cmp_word(res_out.pc_next, 16'h0100 + st[i]);
      cmp_flags(flags_out, 8'h5A);
    end
  endtask

  // Every branch under two flag settings
  task automatic t_branch();
    exu_op_t ops[12] = '{branch_status_set, branch_status_clear, branch_signed_ge,
      branch_signed_lt, branch_unsigned_ge, branch_unsigned_lt, branch_half_carry_set,
      branch_half_carry_clear, branch_overflow_set, branch_overflow_clear,
      branch_transfer_bit_set, branch_transfer_bit_clear};
    logic [11:0] tb = 12'b010101101001; // Taken under flags 0x69, index 0 at bit 0
    logic tk;
    for (int i = 0; i < 12; i++) begin
      for (int p = 0; p < 2; p++) begin
        tk = (p == 1) ? tb[i] : ~tb[i];
        preload((p == 1) ? 8'h69 : 8'h00);
        mk(ops[i], 8'h00, 8'h00);
        rq.pc = 16'h0200;
        rq.bsel = 3'h3;
        rq.offset = 12'h010;
        go(tk ? CYC_TWO : CYC_ONE);
        cmp_word(res_out.pc_next, tk ? 16'h0211 : 16'h0201);
        cmp_flags(flags_out, (p == 1) ? 8'h69 : 8'h00);
      end
    end
  endtask

  // Clock enable freezes a multiply; starts while busy are ignored
  task automatic t_hold();
    preload(8'h00);
    mk(OP_MUL, 8'h03, 8'h05);
    @(negedge mclk_in);
    start_in = 1'b1;
    req_in = rq;
    @(negedge mclk_in);
    ce_in = 1'b0;
    req_in.op = OP_ADD;
    repeat (3) @(negedge mclk_in);
    cmp_bit(done_out, 1'b0);
    cmp_bit(busy_out, 1'b1);
    ce_in = 1'b1;
    @(negedge mclk_in);
    start_in = 1'b0;
    cmp_bit(done_out, 1'b1);
    cmp_word(res_out.data, 16'h000F);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(negedge mclk_in);
    t_reset();
    rst_in = 1'b0;
    t_arith();
    t_word();
    t_logic();
    t_mul();
    t_call();
    t_skip();
    t_branch();
    t_hold();
    end_of_test();
  end
endmodule
